// *** hdl/multi_cpu_resource_interlock.sv ***
/*
  Execution logic for the peer-line test and resource-request operations,
  with the flag word, the delay word and a status word on a plain register
  port. Assumes synchronous active-low peer pins and a core that gives the
  current system/normal mode as a level.
*/
`timescale 1ns/1ns
module multi_cpu_resource_interlock #(
  parameter int DELAY_W = interlock_pkg::DATA_W,
  parameter int STEP_CYCLES = interlock_pkg::DEC_STEP_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire interlock_pkg::regReq_s regReq,
  output logic [interlock_pkg::DATA_W-1:0] rdData,
  input wire logic systemMode,
  input wire logic peerLineN,
  output logic reqLineN,
  output logic busy,
  output logic opDone,
  output interlock_pkg::flags_s flags
);
  import interlock_pkg::*;

  localparam int PACE_W = $clog2(STEP_CYCLES + 1);

  initial
  begin
    if (DELAY_W < 2 || DELAY_W > DATA_W)
    begin
      $error("interlock: DELAY_W must lie in 2..DATA_W");
    end
    if (STEP_CYCLES < 1)
    begin
      $error("interlock: STEP_CYCLES must be at least 1");
    end
  end

  state_e state_q;
  state_e state_d;
  flags_s flags_q;
  flags_s flags_d;
  logic reqOut_q;
  logic reqOut_d;
  logic fault_q;
  logic fault_d;
  logic done_q;
  logic done_d;
  logic [PACE_W-1:0] pace_q;
  logic [PACE_W-1:0] pace_d;
  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdData_d;

  logic peerActive;
  logic wrCmd;
  logic wrDelay;
  logic wrFlags;
  logic wrStatus;
  logic [1:0] opCode;
  logic setFault;
  logic cntLoad;
  logic cntDec;
  logic [DELAY_W-1:0] cntValue;
  logic cntIsOne;
  logic idle;

  assign peerActive = ~peerLineN;
  assign idle = (state_q == ST_IDLE);

  // address decode for writes
  always_comb
  begin
    wrCmd = 1'b0;
    wrDelay = 1'b0;
    wrFlags = 1'b0;
    wrStatus = 1'b0;
    if (regReq.wrEn && regReq.addr == CMD_OFS)
    begin
      wrCmd = 1'b1;
    end
    else if (regReq.wrEn && regReq.addr == DELAY_OFS)
    begin
      wrDelay = 1'b1;
    end
    else if (regReq.wrEn && regReq.addr == FLAGS_OFS)
    begin
      wrFlags = 1'b1;
    end
    else if (regReq.wrEn && regReq.addr == STATUS_OFS)
    begin
      wrStatus = 1'b1;
    end
  end

  assign opCode = regReq.wrData[OP_POS +: 2];

  // delay word only changes under software while no request runs
  assign cntLoad = wrDelay && idle;

  delay_word_counter #(
    .WIDTH(DELAY_W)
  ) delayWord (
    .core_clk(core_clk),
    .rst(rst),
    .clkEn(clkEn),
    .load(cntLoad),
    .loadVal(regReq.wrData[DELAY_W-1:0]),
    .dec(cntDec),
    .value(cntValue),
    .isOne(cntIsOne)
  );

  // operation sequencer
  always_comb
  begin
    state_d = state_q;
    flags_d = flags_q;
    reqOut_d = reqOut_q;
    pace_d = pace_q;
    done_d = 1'b0;
    setFault = 1'b0;
    cntDec = 1'b0;
    // one op at a time; a command written while busy is dropped
    case (state_q)
      ST_IDLE:
      begin
        // flags and command only land while idle; busy writes drop
        if (wrFlags)
        begin
          flags_d = regReq.wrData[5:0];
        end
        if (wrCmd && opCode != OP_NONE)
        begin
          if (!systemMode)
          begin
            setFault = 1'b1;
          end
          else if (opCode == OP_TEST)
          begin
            // other flags kept as they are
            flags_d.s = ~peerActive;
            done_d = 1'b1;
          end
          else if (opCode == OP_REQUEST)
          begin
            state_d = ST_CLEAR_Z;
          end
          else
          begin
            setFault = 1'b1;
          end
        end
      end
      ST_CLEAR_Z:
      begin
        flags_d.z = 1'b0;
        state_d = ST_FIRST_SAMPLE;
      end
      ST_FIRST_SAMPLE:
      begin
        if (peerActive)
        begin
          flags_d.s = 1'b0;
          reqOut_d = 1'b0;
          done_d = 1'b1;
          state_d = ST_IDLE;
        end
        else
        begin
          reqOut_d = 1'b1;
          pace_d = '0;
          state_d = ST_COUNT;
        end
      end
      ST_COUNT:
      begin
        if (pace_q == PACE_W'(STEP_CYCLES - 1))
        begin
          pace_d = '0;
          cntDec = 1'b1;
          // peers answer before this ends
          // stop on the step that takes one to zero
          if (cntIsOne)
          begin
            state_d = ST_FINAL;
          end
        end
        else
        begin
          pace_d = pace_q + PACE_W'(1);
        end
      end
      ST_FINAL:
      begin
        flags_d.s = peerActive;
        flags_d.z = 1'b1;
        reqOut_d = 1'b0;
        done_d = 1'b1;
        state_d = ST_IDLE;
      end
      default:
      begin
        // unused encodings fall back to idle
        state_d = ST_IDLE;
      end
    endcase
  end

  // fault flag: refused op sets it, status write of one clears it
  always_comb
  begin
    fault_d = fault_q;
    if (setFault)
    begin
      // set wins, so a refusal is never lost to a racing clear
      fault_d = 1'b1;
    end
    else if (wrStatus && regReq.wrData[ST_FAULT_POS])
    begin
      fault_d = 1'b0;
    end
  end

  // read data, one cycle after the strobe
  always_comb
  begin
    rdData_d = '0;
    // command word is write-only and reads as zero
    if (regReq.rdEn && regReq.addr == CMD_OFS)
    begin
      rdData_d = '0;
    end
    else if (regReq.rdEn && regReq.addr == DELAY_OFS)
    begin
      rdData_d[DELAY_W-1:0] = cntValue;
    end
    else if (regReq.rdEn && regReq.addr == FLAGS_OFS)
    begin
      rdData_d[5:0] = flags_q;
    end
    else if (regReq.rdEn && regReq.addr == STATUS_OFS)
    begin
      rdData_d[ST_BUSY_POS] = ~idle;
      rdData_d[ST_FAULT_POS] = fault_q;
      rdData_d[ST_OUT_POS] = reqOut_q;
      rdData_d[ST_PEER_POS] = peerActive;
    end
  end

  // sequencer state
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      flags_q <= FLAGS_RST;
      reqOut_q <= 1'b0;
      done_q <= 1'b0;
      pace_q <= '0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      flags_q <= flags_d;
      reqOut_q <= reqOut_d;
      done_q <= done_d;
      pace_q <= pace_d;
    end
  end

  // register-port state; frozen with the sequencer so reads stay coherent
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      fault_q <= 1'b0;
      rdData_q <= '0;
    end
    else if (clkEn)
    begin
      fault_q <= fault_d;
      rdData_q <= rdData_d;
    end
  end

  // logical one drives the pin low
  assign reqLineN = ~reqOut_q;
  assign rdData = rdData_q;
  assign busy = ~idle;
  assign opDone = done_q;
  assign flags = flags_q;

endmodule : multi_cpu_resource_interlock

// *** hdl/interlock_pkg.sv ***
/*
  Shared constants, types and register layout for the multi-processor
  resource interlock. Assumes one processor clock domain and a plain
  strobe-based register port driven by the processor core.
*/
// Notes on behaviour
// - Test op: sign flag copies peer line level
// - Both handshake lines are active-low pins
// - Both ops run only in system mode
// - Request clears zero flag before sampling
// - Busy peer: clear sign, drop out, finish
// - Idle peer: raise outgoing request line
// - Decrement delay word until it reaches zero
// - Second sample: peer active sets sign
package interlock_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // register word offsets
  localparam logic [ADDR_W-1:0] CMD_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] DELAY_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h3;

  // command field and codes
  localparam int OP_POS = 0;
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_TEST = 2'h1;
  localparam logic [1:0] OP_REQUEST = 2'h2;

  // status field positions; bit 1 is write-one-to-clear
  localparam int ST_BUSY_POS = 0;
  localparam int ST_FAULT_POS = 1;
  localparam int ST_OUT_POS = 2;
  localparam int ST_PEER_POS = 3;

  // reset values
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  // processor cycles spent per decrement of the delay word
  localparam int DEC_STEP_CYCLES = 7;

  typedef struct packed {
    logic h;
    logic d;
    logic v;
    logic s;
    logic z;
    logic c;
  } flags_s;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } regReq_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLEAR_Z,
    ST_FIRST_SAMPLE,
    ST_COUNT,
    ST_FINAL
  } state_e;

endpackage : interlock_pkg

// *** hdl/delay_word_counter.sv ***
/*
  Loadable down-counting word register used as the request delay count.
  Assumes load and decrement are never requested in the same cycle.
*/
`timescale 1ns/1ns
module delay_word_counter #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadVal,
  input wire logic dec,
  output logic [WIDTH-1:0] value,
  output logic isOne
);
  import interlock_pkg::*;

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  initial
  begin
    if (WIDTH < 2)
    begin
      $error("delay_word_counter: WIDTH must be at least 2");
    end
  end

  always_comb
  begin
    count_d = count_q;
    if (load)
    begin
      count_d = loadVal;
    end
    else if (dec)
    begin
      // zero wraps round, so a zero count gives the longest delay
      count_d = count_q - WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      count_q <= DELAY_RST[WIDTH-1:0];
    end
    else if (clkEn)
    begin
      count_q <= count_d;
    end
  end

  assign value = count_q;
  assign isOne = (count_q == WIDTH'(1));

endmodule : delay_word_counter

// *** verification/interlock_properties.sv ***
/*
  Checker for the interlock top: flag and pin timing of both operations.
  Assumes one clock, clkEn mostly high, and is bound to the top module.
*/
`timescale 1ns/1ns
module interlock_checker #(
  parameter int DELAY_W = 16,
  parameter int STEP_CYCLES = 7
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire interlock_pkg::regReq_s regReq,
  input wire logic [15:0] rdData,
  input wire logic systemMode,
  input wire logic peerLineN,
  input wire logic reqLineN,
  input wire logic busy,
  input wire logic opDone,
  input wire interlock_pkg::flags_s flags
);
  import interlock_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic cmdW = clkEn && regReq.wrEn && regReq.addr == CMD_OFS && !busy;
  wire logic testW = cmdW && systemMode && regReq.wrData[1:0] == OP_TEST;
  wire logic reqW = cmdW && systemMode && regReq.wrData[1:0] == OP_REQUEST;
  test_sign_a: assert property (
    testW |=> opDone && flags.s == $past(peerLineN)) else $error("test sign wrong");
  test_keep_a: assert property (
    testW |=> {flags.h, flags.d, flags.v, flags.c} == $past({flags.h, flags.d, flags.v, flags.c}))
    else $error("test touched flags");
  req_zclear_a: assert property (
    reqW |-> ##2 !flags.z) else $error("zero not cleared");
  req_early_a: assert property (
    reqW ##2 !peerLineN |=> opDone && reqLineN && !flags.s && !busy)
    else $error("busy peer not refused");
  req_raise_a: assert property (
    reqW ##2 peerLineN |=> !reqLineN && busy) else $error("request not raised");
  line_busy_a: assert property (
    !reqLineN |-> busy) else $error("line low while idle");
  final_sample_a: assert property (
    $rose(reqLineN) |-> opDone && flags.z && !busy && flags.s == !$past(peerLineN))
    else $error("final sample wrong");
  priv_only_a: assert property (
    cmdW && !systemMode |=> !opDone && !busy) else $error("op ran in normal mode");
endmodule : interlock_checker

bind multi_cpu_resource_interlock interlock_checker #(
  .DELAY_W(DELAY_W),
  .STEP_CYCLES(STEP_CYCLES)
) interlockChk (
  .core_clk(core_clk),
  .rst(rst),
  .clkEn(clkEn),
  .regReq(regReq),
  .rdData(rdData),
  .systemMode(systemMode),
  .peerLineN(peerLineN),
  .reqLineN(reqLineN),
  .busy(busy),
  .opDone(opDone),
  .flags(flags)
);

// *** verification/peer_cpu_model.sv ***
/*
  Peer processor on the handshake pins: holds the resource or grants a request.
  Assumes the same clock as the interlock; answers one cycle late.
*/
`timescale 1ns/1ns
module peer_cpu_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic holdRes,
  input wire logic ackOn,
  input wire logic reqLineN,
  output logic peerLineN
);
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      peerLineN <= 1'b1;
    end
    else
    begin
      peerLineN <= !(holdRes || (ackOn && !reqLineN));
    end
  end
endmodule : peer_cpu_model

// *** verification/multi_cpu_resource_interlock_tb.sv ***
/*
  Bench for the interlock: bus tasks, peer model, integer expectations.
  Assumes one clock; pacing shortened to two cycles per decrement.
*/
`timescale 1ns/1ns
module multi_cpu_resource_interlock_tb;
  import interlock_pkg::*;
  localparam int STEP = 2;
  logic core_clk = 0;
  logic rst = 1;
  logic systemMode = 1;
  logic clkEn = 1;
  logic holdRes = 0;
  logic ackOn = 0;
  regReq_s regReq = '0;
  logic [15:0] rdData;
  logic peerLineN;
  logic reqLineN;
  logic busy;
  logic opDone;
  flags_s flags;
  logic pulse;
  logic [15:0] v;
  int badCount = 0;
  int samplesChecked = 0;
  int lowCnt;
  int busyCnt;
  int n;
  int f;
  always #25 core_clk = !core_clk;
  multi_cpu_resource_interlock #(.STEP_CYCLES(STEP)) uut (.core_clk(core_clk), .rst(rst),
    .clkEn(clkEn), .regReq(regReq), .rdData(rdData), .systemMode(systemMode),
    .peerLineN(peerLineN), .reqLineN(reqLineN), .busy(busy), .opDone(opDone), .flags(flags));
  peer_cpu_model peer (.core_clk(core_clk), .rst(rst), .holdRes(holdRes), .ackOn(ackOn),
    .reqLineN(reqLineN), .peerLineN(peerLineN));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      badCount++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one strobe cycle; read data and done pulse caught the cycle after
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    regReq <= '{w, !w, a, d};
    @(posedge core_clk);
    regReq <= '0;
    #1;
    v = rdData;
    pulse = opDone;
    @(posedge core_clk);
  endtask : bus
  task automatic runReq;
    lowCnt = 0;
    busyCnt = 0;
    bus(1'b1, CMD_OFS, 16'h2);
    for (int i = 0; i < 200 && pulse !== 1'b1; i++)
    begin
      @(posedge core_clk);
      #1;
      pulse = opDone;
      lowCnt += int'(reqLineN === 1'b0);
      busyCnt += int'(busy === 1'b1);
    end
    @(posedge core_clk);
  endtask : runReq
  task automatic finish_test;
    if (badCount == 0 && samplesChecked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (3000) @(posedge core_clk);
    badCount++;
    finish_test();
  end
  initial
  begin
    f = $urandom(33);
    repeat (5) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    bus(1'b0, 4'h9, 16'h0);
    chk("unmapped", 16'h0, v);
    for (int i = 0; i < 4; i++)
    begin
      f = $urandom % 64;
      holdRes <= i[0];
      bus(1'b1, FLAGS_OFS, 16'(f));
      bus(1'b1, CMD_OFS, 16'h1);
      chk("done", 16'h1, {15'h0, pulse});
      bus(1'b0, FLAGS_OFS, 16'h0);
      chk("flags", 16'((f & 59) | (i[0] ? 0 : 4)), v);
    end
    clkEn <= 0;
    bus(1'b1, FLAGS_OFS, 16'(~f & 63));
    clkEn <= 1;
    bus(1'b0, FLAGS_OFS, 16'h0);
    chk("frozen", 16'(f & 59), v);
    for (int k = 0; k < 3; k++)
    begin
      n = 1 + $urandom % 6;
      holdRes <= (k == 2);
      ackOn <= (k == 0);
      bus(1'b1, DELAY_OFS, 16'(n));
      runReq();
      chk("low", 16'(k == 2 ? 0 : n * STEP + 1), 16'(lowCnt));
      chk("busy", 16'(k == 2 ? 0 : n * STEP + 1), 16'(busyCnt));
      bus(1'b0, FLAGS_OFS, 16'h0);
      chk("sz", 16'((k == 0 ? 4 : 0) | (k == 2 ? 0 : 2)), v & 16'h6);
      bus(1'b0, DELAY_OFS, 16'h0);
      chk("delay", 16'(k == 2 ? n : 0), v);
    end
    systemMode <= 0;
    holdRes <= 0;
    bus(1'b1, CMD_OFS, 16'h1);
    chk("done", 16'h0, {15'h0, pulse});
    bus(1'b0, STATUS_OFS, 16'h0);
    chk("status", 16'h2, v);
    systemMode <= 1;
    bus(1'b1, STATUS_OFS, 16'h2);
    bus(1'b0, STATUS_OFS, 16'h0);
    chk("status", 16'h0, v);
    bus(1'b1, CMD_OFS, 16'h3);
    chk("done", 16'h0, {15'h0, pulse});
    bus(1'b0, STATUS_OFS, 16'h0);
    chk("status", 16'h2, v);
    finish_test();
  end
endmodule : multi_cpu_resource_interlock_tb
